// File: design/sfr_dev.sv
// How it works
// - select falls, opcode then address shifted in
// - every byte travels MSB first
// - 0Bh: address, one dummy, then data
// - 264 mode: 11 page, 9 offset bits
// - 256 mode: 11 page, 8 offset bits
// - host holds select low whole command
// - page end rolls into next page
// - array end wraps to page zero
// - select rise ends read, output floats
// - array reads never touch the buffers
// - 03h: address then data, no dummy
// - 01h: address then data, no dummy
// - D2h: address, four dummies, page data
// - page read wraps inside its page
// - D4h/D1h buffer one, D6h/D3h buffer two
// - 264 buffer mode: 9 offset bits
// - 256 buffer mode: 8 offset bits
// - D4h/D6h one dummy, others none
// - buffer read wraps to buffer start
`timescale 1ns/1ps
module sfr_dev (
  input wire logic core_clk,
  input wire logic rstn,
  sfr_link_if.dev link,
  input wire logic pg264,
  output logic mem_rd,
  output sfr_pkg::sfr_src_e mem_src,
  output logic [sfr_pkg::PAGE_W-1:0] mem_page,
  output logic [sfr_pkg::OFF_W-1:0] mem_off,
  input wire logic [7:0] mem_data,
  output logic active
);
  typedef struct packed {
    sfr_pkg::sfr_dev_state_e state;
    logic [2:0] bit_cnt;
    logic [7:0] in_sh;
    logic [23:0] addr;
    logic [2:0] cnt;
    logic [2:0] dummies;
    sfr_pkg::sfr_src_e src;
    logic stay;
    logic [sfr_pkg::PAGE_W-1:0] page;
    logic [sfr_pkg::OFF_W-1:0] off;
    logic [7:0] out_sh;
    logic rd;
    logic so;
    logic so_oe_n;
  } sfr_dev_s;

  sfr_dev_s s_q;
  sfr_dev_s s_d;

  logic [2:0] pin_lvl;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;
  logic sck_rise;
  logic sck_fall;
  logic cs_n_lvl;
  logic cs_fall;
  logic si_lvl;

  // ----------------------------------------------------------------
  // pin synchronisers: {cs_n, sck, si}
  // ----------------------------------------------------------------
  sfr_pin_sync #(
    .W(3),
    .RST(3'h4)
  ) u_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .pin_i({link.cs_n, link.sck, link.si}),
    .level_o(pin_lvl),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  assign cs_n_lvl = pin_lvl[2];
  assign cs_fall = pin_fall[2];
  assign sck_rise = pin_rise[1];
  assign sck_fall = pin_fall[1];
  assign si_lvl = pin_lvl[0];

  // ----------------------------------------------------------------
  // opcode decode: {known, source, stay in page, dummy bytes}
  // ----------------------------------------------------------------
  function automatic logic [6:0] decode(input logic [7:0] op);
    logic [6:0] r;
    r = {1'b0, sfr_pkg::SFR_SRC_ARRAY, 1'b0, sfr_pkg::DUMMY_NONE};
    case (op)
      sfr_pkg::OP_ARRAY_FAST:
        r = {1'b1, sfr_pkg::SFR_SRC_ARRAY, 1'b0, sfr_pkg::DUMMY_ARRAY_FAST};
      sfr_pkg::OP_ARRAY_SLOW:
        r = {1'b1, sfr_pkg::SFR_SRC_ARRAY, 1'b0, sfr_pkg::DUMMY_NONE};
      sfr_pkg::OP_ARRAY_LOWPWR:
        r = {1'b1, sfr_pkg::SFR_SRC_ARRAY, 1'b0, sfr_pkg::DUMMY_NONE};
      sfr_pkg::OP_PAGE:
        r = {1'b1, sfr_pkg::SFR_SRC_ARRAY, 1'b1, sfr_pkg::DUMMY_PAGE};
      sfr_pkg::OP_BUF1_FAST:
        r = {1'b1, sfr_pkg::SFR_SRC_BUF1, 1'b1, sfr_pkg::DUMMY_BUF_FAST};
      sfr_pkg::OP_BUF1_SLOW:
        r = {1'b1, sfr_pkg::SFR_SRC_BUF1, 1'b1, sfr_pkg::DUMMY_NONE};
      sfr_pkg::OP_BUF2_FAST:
        r = {1'b1, sfr_pkg::SFR_SRC_BUF2, 1'b1, sfr_pkg::DUMMY_BUF_FAST};
      sfr_pkg::OP_BUF2_SLOW:
        r = {1'b1, sfr_pkg::SFR_SRC_BUF2, 1'b1, sfr_pkg::DUMMY_NONE};
      default:
        r = {1'b0, sfr_pkg::SFR_SRC_ARRAY, 1'b0, sfr_pkg::DUMMY_NONE};
    endcase
    return r;
  endfunction : decode

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [7:0] byte_in;
    logic [6:0] dec;
    logic [23:0] a;
    logic start_data;
    logic [sfr_pkg::OFF_W-1:0] last_off;
    byte_in = '0;
    dec = '0;
    a = s_q.addr;
    start_data = 1'b0;
    last_off = pg264 ? sfr_pkg::LAST_OFF_264 : sfr_pkg::LAST_OFF_256;
    s_d = s_q;
    s_d.rd = 1'b0;

    // fetched byte arrives with the read strobe
    if (s_q.rd)
      s_d.out_sh = mem_data;

    // fall tested first: synced level still reads high while it is flagged
    if (cs_fall)
    begin
      s_d.state = sfr_pkg::SFR_D_OPC;
      s_d.bit_cnt = '0;
      s_d.cnt = '0;
    end
    else if (cs_n_lvl)
    begin
      s_d.state = sfr_pkg::SFR_D_IDLE;
      s_d.so_oe_n = 1'b1;
      s_d.rd = 1'b0;
    end
    else if (sck_rise && s_q.state != sfr_pkg::SFR_D_IDLE)
    begin
      byte_in = {s_q.in_sh[6:0], si_lvl};
      s_d.in_sh = byte_in;
      s_d.bit_cnt = s_q.bit_cnt + 3'h1;
      if (s_q.bit_cnt == sfr_pkg::BIT_LAST)
      begin
        case (s_q.state)
          sfr_pkg::SFR_D_OPC:
          begin
            dec = decode(byte_in);
            s_d.src = sfr_pkg::sfr_src_e'(dec[5:4]);
            s_d.stay = dec[3];
            s_d.dummies = dec[2:0];
            s_d.cnt = '0;
            s_d.state = dec[6] ? sfr_pkg::SFR_D_ADDR : sfr_pkg::SFR_D_IGNORE;
          end
          sfr_pkg::SFR_D_ADDR:
          begin
            a = {s_q.addr[15:0], byte_in};
            s_d.addr = a;
            s_d.cnt = s_q.cnt + 3'h1;
            if (s_q.cnt == sfr_pkg::ADDR_BYTES - 3'h1)
            begin
              if (pg264)
              begin
                s_d.page = a[sfr_pkg::OFF264_W +: sfr_pkg::PAGE_W];
                s_d.off = a[sfr_pkg::OFF264_W-1:0];
              end
              else
              begin
                s_d.page = a[sfr_pkg::OFF256_W +: sfr_pkg::PAGE_W];
                s_d.off = {1'b0, a[sfr_pkg::OFF256_W-1:0]};
              end
              s_d.cnt = '0;
              if (s_q.dummies == sfr_pkg::DUMMY_NONE)
                start_data = 1'b1;
              else
                s_d.state = sfr_pkg::SFR_D_DUMMY;
            end
          end
          sfr_pkg::SFR_D_DUMMY:
          begin
            s_d.cnt = s_q.cnt + 3'h1;
            if (s_q.cnt == s_q.dummies - 3'h1)
              start_data = 1'b1;
          end
          default:
          begin
            s_d.state = s_q.state;
          end
        endcase
      end
    end
    else if (sck_fall && s_q.state == sfr_pkg::SFR_D_DATA)
    begin
      s_d.so = s_q.out_sh[7];
      s_d.so_oe_n = 1'b0;
      s_d.out_sh = {s_q.out_sh[6:0], 1'b0};
      s_d.cnt = s_q.cnt + 3'h1;
      if (s_q.cnt == sfr_pkg::BIT_LAST)
      begin
        if (s_q.off == last_off)
        begin
          s_d.off = '0;
          if (!s_q.stay)
            s_d.page = s_q.page + 11'h001;
        end
        else
          s_d.off = s_q.off + 9'h001;
        // fetched straight away so the next bit has no gap
        s_d.rd = 1'b1;
      end
    end

    if (start_data)
    begin
      s_d.state = sfr_pkg::SFR_D_DATA;
      s_d.cnt = '0;
      s_d.rd = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= '0;
      s_q.so_oe_n <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // read-only memory port
  assign mem_rd = s_q.rd;
  assign mem_src = s_q.src;
  assign mem_page = s_q.page;
  assign mem_off = s_q.off;
  assign active = (s_q.state != sfr_pkg::SFR_D_IDLE);
  assign link.so_o = s_q.so;
  assign link.so_oe_n = s_q.so_oe_n;
endmodule : sfr_dev

// File: design/sfr_pkg.sv
package sfr_pkg;

  // ----------------------------------------------------------------
  // read opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_ARRAY_FAST = 8'h0B;
  localparam logic [7:0] OP_ARRAY_SLOW = 8'h03;
  localparam logic [7:0] OP_ARRAY_LOWPWR = 8'h01;
  localparam logic [7:0] OP_PAGE = 8'hD2;
  localparam logic [7:0] OP_BUF1_FAST = 8'hD4;
  localparam logic [7:0] OP_BUF1_SLOW = 8'hD1;
  localparam logic [7:0] OP_BUF2_FAST = 8'hD6;
  localparam logic [7:0] OP_BUF2_SLOW = 8'hD3;

  // ----------------------------------------------------------------
  // framing
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_BYTES = 3'h3;
  localparam logic [2:0] DUMMY_NONE = 3'h0;
  localparam logic [2:0] DUMMY_ARRAY_FAST = 3'h1;
  localparam logic [2:0] DUMMY_PAGE = 3'h4;
  localparam logic [2:0] DUMMY_BUF_FAST = 3'h1;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // ----------------------------------------------------------------
  // address geometry
  // ----------------------------------------------------------------
  localparam int PAGE_W = 11;
  localparam int OFF_W = 9;
  localparam int OFF264_W = 9;
  localparam int OFF256_W = 8;
  localparam logic [8:0] LAST_OFF_264 = 9'h107;
  localparam logic [8:0] LAST_OFF_256 = 9'h0FF;

  typedef enum logic [1:0] {
    SFR_SRC_ARRAY = 2'h0,
    SFR_SRC_BUF1 = 2'h1,
    SFR_SRC_BUF2 = 2'h2
  } sfr_src_e;

  typedef enum logic [2:0] {
    SFR_D_IDLE = 3'h0,
    SFR_D_OPC = 3'h1,
    SFR_D_ADDR = 3'h3,
    SFR_D_DUMMY = 3'h2,
    SFR_D_DATA = 3'h6,
    SFR_D_IGNORE = 3'h7
  } sfr_dev_state_e;

  typedef enum logic [1:0] {
    SFR_H_IDLE = 2'h0,
    SFR_H_RUN = 2'h1,
    SFR_H_END = 2'h3
  } sfr_host_state_e;

endpackage : sfr_pkg

// File: design/sfr_link_if.sv
`timescale 1ns/1ps
interface sfr_link_if;
  logic sck;
  logic cs_n;
  logic si;
  logic so_o;
  logic so_oe_n;
  logic so_line;

  // undriven serial output floats high through the board pull-up
  assign so_line = so_oe_n ? 1'b1 : so_o;

  modport dev (
    input sck,
    input cs_n,
    input si,
    output so_o,
    output so_oe_n
  );

  modport host (
    output sck,
    output cs_n,
    output si,
    input so_line
  );
endinterface : sfr_link_if

// File: design/sfr_pin_sync.sv
`timescale 1ns/1ps
module sfr_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);
  typedef struct packed {
    logic [W-1:0] f1;
    logic [W-1:0] f2;
    logic [W-1:0] f3;
    logic [W-1:0] lvl;
  } sfr_sync_s;

  sfr_sync_s s_q;
  sfr_sync_s s_d;
  logic [W-1:0] agree;

  // a change counts only once the second and third stages agree
  assign agree = ~(s_q.f2 ^ s_q.f3);

  always_comb
  begin
    s_d = s_q;
    s_d.f1 = pin_i;
    s_d.f2 = s_q.f1;
    s_d.f3 = s_q.f2;
    s_d.lvl = (agree & s_q.f3) | (~agree & s_q.lvl);
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      s_q <= {RST, RST, RST, RST};
    else
      s_q <= s_d;
  end

  assign level_o = s_q.lvl;
  assign rise_o = agree & s_q.f3 & ~s_q.lvl;
  assign fall_o = agree & ~s_q.f3 & s_q.lvl;
endmodule : sfr_pin_sync

// File: design/sfr_host.sv
`timescale 1ns/1ps
module sfr_host #(
  parameter int HALF = 10,
  parameter int LEN_W = 16
) (
  input wire logic core_clk,
  input wire logic rstn,
  sfr_link_if.host link,
  input wire logic start,
  input wire logic [7:0] cmd_op,
  input wire logic [23:0] cmd_addr,
  input wire logic [2:0] cmd_dummies,
  input wire logic [LEN_W-1:0] cmd_len,
  output logic busy,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic done
);
  typedef struct packed {
    sfr_pkg::sfr_host_state_e state;
    logic [7:0] div;
    logic sck;
    logic cs_n;
    logic si;
    logic [7:0] tx_sh;
    logic [23:0] addr;
    logic [7:0] rx_sh;
    logic [2:0] bit_cnt;
    logic [3:0] hdr;
    logic [2:0] dummies;
    logic [LEN_W-1:0] left;
    logic [7:0] rx_data;
    logic rx_valid;
    logic done;
  } sfr_host_s;

  localparam logic [7:0] DIV_LAST = 8'(HALF - 1);
  // opcode byte is counted down with the header too
  localparam logic [3:0] OPC_BYTES = 4'h1;

  sfr_host_s s_q;
  sfr_host_s s_d;
  logic so_lvl;

  sfr_pin_sync #(
    .W(1),
    .RST(1'b1)
  ) u_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .pin_i(link.so_line),
    .level_o(so_lvl),
    .rise_o(),
    .fall_o()
  );

  // ----------------------------------------------------------------
  // mode 0 shifter, sck idles low
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [7:0] nxt;
    nxt = '0;
    s_d = s_q;
    s_d.rx_valid = 1'b0;
    s_d.done = 1'b0;
    case (s_q.state)
      sfr_pkg::SFR_H_IDLE:
      begin
        if (start)
        begin
          s_d.state = sfr_pkg::SFR_H_RUN;
          s_d.cs_n = 1'b0;
          s_d.sck = 1'b0;
          s_d.div = '0;
          s_d.tx_sh = cmd_op;
          s_d.si = cmd_op[7];
          s_d.addr = cmd_addr;
          s_d.bit_cnt = '0;
          s_d.hdr = OPC_BYTES + {1'b0, sfr_pkg::ADDR_BYTES} + {1'b0, cmd_dummies};
          s_d.dummies = cmd_dummies;
          s_d.left = (cmd_len == '0) ? LEN_W'(1) : cmd_len;
        end
      end
      sfr_pkg::SFR_H_RUN:
      begin
        s_d.div = s_q.div + 8'h01;
        if (s_q.div == DIV_LAST)
        begin
          s_d.div = '0;
          s_d.sck = ~s_q.sck;
          if (!s_q.sck)
          begin
            s_d.rx_sh = {s_q.rx_sh[6:0], so_lvl};
            s_d.bit_cnt = s_q.bit_cnt + 3'h1;
            if (s_q.bit_cnt == sfr_pkg::BIT_LAST)
            begin
              if (s_q.hdr == 4'h0)
              begin
                s_d.rx_data = {s_q.rx_sh[6:0], so_lvl};
                s_d.rx_valid = 1'b1;
                s_d.left = s_q.left - LEN_W'(1);
              end
              else
                s_d.hdr = s_q.hdr - 4'h1;
            end
          end
          else if (s_q.bit_cnt == 3'h0)
          begin
            if (s_q.hdr == 4'h0 && s_q.left == '0)
            begin
              s_d.cs_n = 1'b1;
              s_d.done = 1'b1;
              s_d.state = sfr_pkg::SFR_H_END;
            end
            else
            begin
              if (s_q.hdr > {1'b0, s_q.dummies})
              begin
                nxt = s_q.addr[23:16];
                s_d.addr = {s_q.addr[15:0], 8'h00};
              end
              s_d.tx_sh = nxt;
              s_d.si = nxt[7];
            end
          end
          else
          begin
            s_d.tx_sh = {s_q.tx_sh[6:0], 1'b0};
            s_d.si = s_q.tx_sh[6];
          end
        end
      end
      sfr_pkg::SFR_H_END:
      begin
        // deselect time before the next command
        s_d.div = s_q.div + 8'h01;
        if (s_q.div == DIV_LAST)
        begin
          s_d.div = '0;
          s_d.state = sfr_pkg::SFR_H_IDLE;
        end
      end
      default:
      begin
        s_d.state = sfr_pkg::SFR_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= '0;
      s_q.cs_n <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign link.sck = s_q.sck;
  assign link.cs_n = s_q.cs_n;
  assign link.si = s_q.si;
  assign busy = (s_q.state != sfr_pkg::SFR_H_IDLE);
  assign rx_data = s_q.rx_data;
  assign rx_valid = s_q.rx_valid;
  assign done = s_q.done;
endmodule : sfr_host

// File: testbench/sfr_link_monitor.sv
`timescale 1ns/1ps
module sfr_link_monitor (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic so_o,
  input wire logic so_oe_n,
  input wire logic so_line
);
  logic [15:0] rise_cnt_q;
  logic sck_q;

  default clocking mon_cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  // ----------------------------------------------------------------
  // sck rises seen in the current frame
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rise_cnt_q <= 16'h0000;
      sck_q <= 1'b0;
    end
    else
    begin
      sck_q <= sck;
      if (cs_n)
        rise_cnt_q <= 16'h0000;
      else if (sck && !sck_q)
        rise_cnt_q <= rise_cnt_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // link checks
  // ----------------------------------------------------------------
  AST_IDLE_SCK_LOW: assert property (cs_n |-> !sck)
    else $error("sck high while deselected");
  // a shorter high phase outruns the device synchroniser
  AST_SCK_HALF_MIN: assert property ($rose(sck) |-> sck [*8])
    else $error("sck high phase too short");
  AST_SI_ON_LOW: assert property ($changed(si) |-> !sck)
    else $error("si moved while sck high");
  AST_WHOLE_BYTES: assert property ($rose(cs_n) |-> rise_cnt_q >= 16'h0020 && rise_cnt_q[2:0] == 3'h0)
    else $error("frame not whole bytes");
  AST_OE_AFTER_ADDR: assert property ($fell(so_oe_n) |-> !cs_n && rise_cnt_q >= 16'h0020)
    else $error("output enabled before address done");
  AST_OE_ON_FALL: assert property ($fell(so_oe_n) |-> !sck)
    else $error("output enabled while sck high");
  AST_SO_ON_LOW: assert property (!so_oe_n && $changed(so_o) |-> !sck)
    else $error("so moved while sck high");
  AST_OE_HOLDS: assert property (!so_oe_n && !cs_n |=> !so_oe_n)
    else $error("output gap inside data phase");
  AST_OE_OFF_RISE: assert property ($rose(cs_n) |-> ##[1:8] so_oe_n)
    else $error("output still driven after deselect");
  AST_FLOAT_IDLE: assert property (cs_n [*8] |-> so_oe_n && so_line)
    else $error("so not floating high when idle");
endmodule : sfr_link_monitor

// File: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic core_clk;
  logic rstn;
  logic pg264;
  logic start;
  logic [7:0] cmd_op;
  logic [23:0] cmd_addr;
  logic [2:0] cmd_dummies;
  logic [15:0] cmd_len;
  logic busy;
  logic [7:0] rx_data;
  logic rx_valid;
  logic done;
  logic mem_rd;
  sfr_pkg::sfr_src_e mem_src;
  logic [sfr_pkg::PAGE_W-1:0] mem_page;
  logic [sfr_pkg::OFF_W-1:0] mem_off;
  logic [7:0] mem_data;
  logic active;
  int num_errors = 0;
  int checks = 0;
  int rd_cnt = 0;
  logic [7:0] rx_q[$];

  sfr_link_if link ();

  // byte model: source and offset show in the value, low page bits only for the array source
  function automatic logic [7:0] pat(input logic [1:0] s, input logic [10:0] p,
      input logic [8:0] o);
    pat = o[7:0] ^ {(s == 2'h0) ? p[3:0] : 4'h0, o[8], 1'b0, s};
  endfunction : pat

  assign mem_data = pat(mem_src, mem_page, mem_off);

  sfr_dev u_sfr_dev (.core_clk, .rstn, .link, .pg264, .mem_rd, .mem_src, .mem_page,
    .mem_off, .mem_data, .active);

  sfr_host #(.HALF(10), .LEN_W(16)) u_sfr_host (.core_clk, .rstn, .link, .start, .cmd_op,
    .cmd_addr, .cmd_dummies, .cmd_len, .busy, .rx_data, .rx_valid, .done);

  sfr_link_monitor u_sfr_link_monitor (.core_clk, .rstn, .sck(link.sck), .cs_n(link.cs_n),
    .si(link.si), .so_o(link.so_o), .so_oe_n(link.so_oe_n), .so_line(link.so_line));

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  always @(negedge core_clk)
  begin
    if (rx_valid === 1'b1)
      rx_q.push_back(rx_data);
    if (mem_rd === 1'b1)
      rd_cnt++;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  // kind 0 array stream, 1 wrap in page or buffer, 2 ignored opcode
  task automatic run(input logic [7:0] op, input logic p264, input logic [23:0] addr,
      input logic [2:0] dum, input int len, input int kind, input logic [1:0] src);
    logic [10:0] pg;
    logic [8:0] off;
    logic [8:0] last;
    int n;
    int rd0;
    pg = p264 ? addr[19:9] : addr[18:8];
    off = p264 ? addr[8:0] : {1'b0, addr[7:0]};
    last = p264 ? sfr_pkg::LAST_OFF_264 : sfr_pkg::LAST_OFF_256;
    rx_q.delete();
    rd0 = rd_cnt;
    @(posedge core_clk);
    pg264 <= p264;
    repeat (2) @(posedge core_clk);
    start <= 1'b1;
    cmd_op <= op;
    cmd_addr <= addr;
    cmd_dummies <= dum;
    cmd_len <= 16'(len);
    @(posedge core_clk);
    start <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20000)
    begin
      @(negedge core_clk);
      n++;
    end
    while (busy === 1'b1 && n < 20000)
    begin
      @(negedge core_clk);
      n++;
    end
    // device sees the select rise through its synchroniser
    repeat (8) @(negedge core_clk);
    check("so_oe_n", {7'h00, link.so_oe_n}, 8'h01);
    check("so_line", {7'h00, link.so_line}, 8'h01);
    check("active", {7'h00, active}, 8'h00);
    check("count", 8'(rx_q.size()), 8'(len));
    check("in_time", 8'(n < 20000), 8'h01);
    check("mem_rd", 8'(rd_cnt - rd0), (kind == 2) ? 8'h00 : 8'(len + 1));
    check("mem_src", {6'h00, mem_src}, {6'h00, src});
    for (int i = 0; i < len && i < rx_q.size(); i++)
    begin
      check("rx_data", rx_q[i], (kind == 2) ? 8'hFF : pat(src, pg, off));
      if (off == last)
      begin
        off = 9'h000;
        if (kind == 0)
          pg = pg + 11'h001;
      end
      else
        off = off + 9'h001;
    end
    $display("test opcode %h done", op);
  endtask : run

  initial
  begin
    rstn = 1'b0;
    pg264 = 1'b0;
    start = 1'b0;
    cmd_op = 8'h00;
    cmd_addr = 24'h000000;
    cmd_dummies = 3'h0;
    cmd_len = 16'h0001;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    run(sfr_pkg::OP_ARRAY_FAST, 1'b1, 24'h000B06, 3'h1, 4, 0, 2'h0);
    run(sfr_pkg::OP_ARRAY_SLOW, 1'b0, 24'h07FFFE, 3'h0, 4, 0, 2'h0);
    run(sfr_pkg::OP_ARRAY_LOWPWR, 1'b1, 24'h0FFF07, 3'h0, 2, 0, 2'h0);
    run(sfr_pkg::OP_ARRAY_FAST, 1'b0, 24'hF80001, 3'h1, 1, 0, 2'h0);
    run(sfr_pkg::OP_PAGE, 1'b0, 24'h0003FF, 3'h4, 3, 1, 2'h0);
    run(sfr_pkg::OP_PAGE, 1'b1, 24'h000707, 3'h4, 2, 1, 2'h0);
    run(sfr_pkg::OP_BUF1_FAST, 1'b1, 24'hFFFF07, 3'h1, 3, 1, 2'h1);
    run(sfr_pkg::OP_BUF1_SLOW, 1'b0, 24'hFFFFFF, 3'h0, 3, 1, 2'h1);
    run(sfr_pkg::OP_BUF2_FAST, 1'b0, 24'h1234FE, 3'h1, 3, 1, 2'h2);
    run(sfr_pkg::OP_BUF2_SLOW, 1'b1, 24'hABCD05, 3'h0, 4, 1, 2'h2);
    run(8'h5A, 1'b0, 24'h000010, 3'h0, 2, 2, 2'h0);
    finish_test();
  end

  initial
  begin
    repeat (90000) @(posedge core_clk);
    num_errors++;
    $display("watchdog expired");
    finish_test();
  end
endmodule : testbench
